// ---- pisb_pkg.sv ----
/*
 * Constants for the transceiver interrupt status bank: register indices,
 * byte addresses, flag positions, reset values and configuration layout.
 * Assumes a 32-bit APB slave with word-aligned registers behind it.
 */
package pisb_pkg;

    // ************************************************************
    // Bus and register map
    // ************************************************************
    localparam int unsigned ADDR_W     = 8;
    localparam logic [7:0]  IDX_CFG    = 8'h18;
    localparam logic [7:0]  IDX_MASK   = 8'h19;
    localparam logic [7:0]  IDX_FLAGS  = 8'h1A;
    localparam logic [7:0]  ADDR_CFG   = IDX_CFG << 2;
    localparam logic [7:0]  ADDR_MASK  = IDX_MASK << 2;
    localparam logic [7:0]  ADDR_FLAGS = IDX_FLAGS << 2;

    // ************************************************************
    // Flag positions
    // ************************************************************
    localparam int unsigned BIT_SUMMARY   = 15;
    localparam int unsigned BIT_SPEED_CHG = 14;
    localparam int unsigned BIT_LINK_CHG  = 13;
    localparam int unsigned BIT_DPLX_CHG  = 12;
    localparam int unsigned BIT_AN_ERR    = 11;
    localparam int unsigned BIT_AN_DONE   = 10;
    localparam int unsigned BIT_SYM_ERR   = 8;
    localparam int unsigned BIT_FAST_FAIL = 7;
    localparam int unsigned BIT_FALSE_CAR = 3;
    localparam int unsigned BIT_DOWNSHIFT = 2;
    localparam int unsigned BIT_MS_ERR    = 1;
    localparam int unsigned BIT_RX_ERR    = 0;
    localparam logic [15:0] FLAG_IMPL     = 16'hFD8F;
    localparam logic [15:0] FLAG_RESET    = 16'h0000;

    // ************************************************************
    // Configuration and mask layout
    // ************************************************************
    localparam int unsigned CFG_AN_EN     = 0;
    localparam int unsigned CFG_ADV_LSB   = 1;
    localparam int unsigned CFG_ADV_W     = 4;
    localparam logic [15:0] CFG_IMPL      = 16'h001F;
    localparam logic [15:0] CFG_RESET     = 16'h001F;
    localparam logic [15:0] MASK_RESET    = 16'h0000;

endpackage

// ---- pisb_evt_if.sv ----
/*
 * Carrier between the register bank and the event detector: qualified
 * event pulses one way, gating configuration the other.
 * Assumes both ends run on the same clock and reset.
 */
`timescale 1ns/1ps
interface pisb_evt_if;
    // Event pulses, one cycle each, by flag position
    logic [15:0] evt;
    // Gating configuration from software
    logic        an_enable;
    logic [3:0]  adv_speeds;

    modport src (input an_enable, input adv_speeds, output evt);
    modport dst (output an_enable, output adv_speeds, input evt);
endinterface

// ---- pisb_event_detect.sv ----
/*
 * Event detector: turns link status levels into change pulses and gates
 * the raw event pulses by the software configuration.
 * Assumes all inputs come from logic on the same clock.
 */
`timescale 1ns/1ps
module pisb_event_detect (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Link status levels
    input  wire logic [1:0] link_speed,
    input  wire logic       link_up,
    input  wire logic       full_duplex,
    // Raw event pulses
    input  wire logic [15:0] raw_evt,
    input  wire logic       rx_carrier_ext,
    // Qualified events out
    pisb_evt_if.src         ev
);
    logic [1:0] speed_prev_reg;
    logic       link_prev_reg;
    logic       dplx_prev_reg;
    logic       primed_reg;
    logic [15:0] evt_next;

    // ************************************************************
    // Level history
    // ************************************************************
    // Primed after first sample so reset values never look like changes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            speed_prev_reg <= 2'h0;
            link_prev_reg  <= 1'b0;
            dplx_prev_reg  <= 1'b0;
            primed_reg     <= 1'b0;
        end else begin
            speed_prev_reg <= link_speed;
            link_prev_reg  <= link_up;
            dplx_prev_reg  <= full_duplex;
            primed_reg     <= 1'b1;
        end
    end

    // ************************************************************
    // Qualification
    // ************************************************************
    // Change pulses and gating of raw pulses
    always_comb begin
        evt_next = raw_evt & pisb_pkg::FLAG_IMPL;
        evt_next[pisb_pkg::BIT_SUMMARY]   = 1'b0;
        evt_next[pisb_pkg::BIT_SPEED_CHG] = primed_reg && (link_speed != speed_prev_reg)
                                            && ev.an_enable;
        evt_next[pisb_pkg::BIT_LINK_CHG]  = primed_reg && (link_up != link_prev_reg);
        evt_next[pisb_pkg::BIT_DPLX_CHG]  = primed_reg && (full_duplex != dplx_prev_reg)
                                            && ev.an_enable;
        evt_next[pisb_pkg::BIT_DOWNSHIFT] = raw_evt[pisb_pkg::BIT_DOWNSHIFT]
                                            && (&ev.adv_speeds);
        evt_next[pisb_pkg::BIT_RX_ERR]    = raw_evt[pisb_pkg::BIT_RX_ERR]
                                            && !rx_carrier_ext;
    end

    assign ev.evt = evt_next;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_link_change;
        (primed_reg && $past(primed_reg) && $changed(link_up)) |-> ev.evt[pisb_pkg::BIT_LINK_CHG];
    endproperty
    a_link_change: assert property (p_link_change) else $error("link change not flagged");

    property p_speed_change;
        ($past(primed_reg) && $changed(link_speed) && ev.an_enable) |-> ev.evt[pisb_pkg::BIT_SPEED_CHG];
    endproperty
    a_speed_change: assert property (p_speed_change) else $error("speed change not flagged");
endmodule

// ---- pisb_top.sv ----
/*
 * Interrupt status bank of the transceiver: APB slave holding the event
 * flag register, a mask and a gating configuration, plus the interrupt.
 * Assumes the event inputs come from transceiver logic on SYS_CLK and
 * that the APB master follows the usual setup and access phases.
 */
`timescale 1ns/1ps
module pisb_top (
    // Clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        ARST_N,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Link status levels
    input  wire logic [1:0]  LINK_SPEED,
    input  wire logic        LINK_UP,
    input  wire logic        FULL_DUPLEX,
    // Event pulses
    input  wire logic        AN_ERROR,
    input  wire logic        AN_COMPLETE,
    input  wire logic        SYMBOL_ERROR,
    input  wire logic        FAST_LINK_FAIL,
    input  wire logic        FALSE_CARRIER,
    input  wire logic        SPEED_DOWNSHIFT,
    input  wire logic        MS_RESOLVE_ERROR,
    input  wire logic        RX_ERROR,
    input  wire logic        RX_CARRIER_EXT,
    // Interrupt
    output logic             IRQ
);

    // ************************************************************
    // Declarations
    // ************************************************************
    logic        rst_meta_reg;
    logic        rst_n_reg;
    logic [15:0] flags_reg;
    logic [15:0] flags_next;
    logic [15:0] mask_reg;
    logic [15:0] cfg_reg;
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic        pready_reg;
    logic        pslverr_reg;
    logic        pslverr_next;
    logic        irq_reg;
    logic [15:0] raw_evt;
    logic [15:0] flag_clr;
    logic        setup_phase;
    logic        access_done;
    logic        rd_flags_done;
    logic        wr_done;
    logic        evt_any;

    pisb_evt_if evt_bus ();

    // ************************************************************
    // Helpers
    // ************************************************************
    // True when the address selects the given target word
    function automatic logic addr_is(input logic [7:0] addr, input logic [7:0] target);
        addr_is = (addr == target);
    endfunction

    function automatic logic addr_mapped(input logic [7:0] addr);
        addr_mapped = addr_is(addr, pisb_pkg::ADDR_FLAGS) || addr_is(addr, pisb_pkg::ADDR_MASK)
                      || addr_is(addr, pisb_pkg::ADDR_CFG);
    endfunction

    // ************************************************************
    // Reset release
    // ************************************************************
    // Two stages so release is clean on SYS_CLK
    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg    <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg    <= rst_meta_reg;
        end
    end

    // ************************************************************
    // Event detection
    // ************************************************************
    // Raw pulses placed at their flag positions
    always_comb begin
        raw_evt = 16'h0000;
        raw_evt[pisb_pkg::BIT_AN_ERR]    = AN_ERROR;
        raw_evt[pisb_pkg::BIT_AN_DONE]   = AN_COMPLETE;
        raw_evt[pisb_pkg::BIT_SYM_ERR]   = SYMBOL_ERROR;
        raw_evt[pisb_pkg::BIT_FAST_FAIL] = FAST_LINK_FAIL;
        raw_evt[pisb_pkg::BIT_FALSE_CAR] = FALSE_CARRIER;
        raw_evt[pisb_pkg::BIT_DOWNSHIFT] = SPEED_DOWNSHIFT;
        raw_evt[pisb_pkg::BIT_MS_ERR]    = MS_RESOLVE_ERROR;
        raw_evt[pisb_pkg::BIT_RX_ERR]    = RX_ERROR;
    end

    // Configuration handed to the detector
    assign evt_bus.an_enable  = cfg_reg[pisb_pkg::CFG_AN_EN];
    assign evt_bus.adv_speeds = cfg_reg[pisb_pkg::CFG_ADV_LSB +: pisb_pkg::CFG_ADV_W];

    pisb_event_detect u_detect (
        .clk            (SYS_CLK),
        .rst_n          (rst_n_reg),
        .link_speed     (LINK_SPEED),
        .link_up        (LINK_UP),
        .full_duplex    (FULL_DUPLEX),
        .raw_evt        (raw_evt),
        .rx_carrier_ext (RX_CARRIER_EXT),
        .ev             (evt_bus.src)
    );

    // ************************************************************
    // APB phase decode
    // ************************************************************
    // Setup cycle loads read data; access completes one cycle later
    assign setup_phase   = PSEL && !PENABLE;
    assign access_done   = PSEL && PENABLE && pready_reg;
    assign wr_done       = access_done && PWRITE;
    assign rd_flags_done = access_done && !PWRITE && addr_is(PADDR, pisb_pkg::ADDR_FLAGS);

    // ************************************************************
    // Event flags
    // ************************************************************
    // Clear only what the completing read returned
    assign flag_clr = rd_flags_done ? prdata_reg[15:0] : 16'h0000;
    assign evt_any  = |(evt_bus.evt & pisb_pkg::FLAG_IMPL & 16'h7FFF);

    // Per-bit sticky update: a new event wins over the clear
    genvar gi;
    generate
        for (gi = 0; gi < 15; gi++) begin : g_flag
            assign flags_next[gi] = pisb_pkg::FLAG_IMPL[gi]
                                    && (evt_bus.evt[gi] || (flags_reg[gi] && !flag_clr[gi]));
        end
    endgenerate

    // Summary flag follows any cause
    assign flags_next[pisb_pkg::BIT_SUMMARY] = evt_any
                                               || (flags_reg[pisb_pkg::BIT_SUMMARY]
                                                   && !flag_clr[pisb_pkg::BIT_SUMMARY]);

    // Flags ignore writes and start clear
    always_ff @(posedge SYS_CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            flags_reg <= pisb_pkg::FLAG_RESET;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // ************************************************************
    // Writable registers
    // ************************************************************
    // Mask and gating configuration
    always_ff @(posedge SYS_CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            mask_reg <= pisb_pkg::MASK_RESET;
            cfg_reg  <= pisb_pkg::CFG_RESET;
        end else if (wr_done) begin
            if (addr_is(PADDR, pisb_pkg::ADDR_MASK)) begin
                mask_reg <= PWDATA[15:0] & pisb_pkg::FLAG_IMPL;
            end
            if (addr_is(PADDR, pisb_pkg::ADDR_CFG)) begin
                cfg_reg <= PWDATA[15:0] & pisb_pkg::CFG_IMPL;
            end
        end
    end

    // ************************************************************
    // APB answer
    // ************************************************************
    // Read data and error chosen during the setup cycle
    always_comb begin
        prdata_next  = prdata_reg;
        pslverr_next = 1'b0;
        if (setup_phase) begin
            prdata_next  = 32'h0000_0000;
            pslverr_next = !addr_mapped(PADDR);
            if (!PWRITE) begin
                if (addr_is(PADDR, pisb_pkg::ADDR_FLAGS)) begin
                    prdata_next[15:0] = flags_reg;
                end else if (addr_is(PADDR, pisb_pkg::ADDR_MASK)) begin
                    prdata_next[15:0] = mask_reg;
                end else if (addr_is(PADDR, pisb_pkg::ADDR_CFG)) begin
                    prdata_next[15:0] = cfg_reg;
                end
            end
        end
    end

    // Ready in the first access cycle, one wait-free transfer
    always_ff @(posedge SYS_CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
        end else begin
            pready_reg  <= setup_phase;
            pslverr_reg <= pslverr_next;
            prdata_reg  <= prdata_next;
        end
    end

    // ************************************************************
    // Interrupt
    // ************************************************************
    // High while an unmasked flag is pending
    always_ff @(posedge SYS_CLK or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(flags_reg & mask_reg);
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign PRDATA  = prdata_reg;
    assign PREADY  = pready_reg;
    assign PSLVERR = pslverr_reg;
    assign IRQ     = irq_reg;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!rst_n_reg);

    // Completed read leaves only bits not returned, unless new events came
    property p_read_clears;
        (rd_flags_done && (evt_bus.evt == 16'h0000))
            |=> (flags_reg == ($past(flags_reg) & ~$past(prdata_reg[15:0])));
    endproperty
    a_read_clears: assert property (p_read_clears) else $error("read did not clear returned flags");

    // A symbol error flag read twice in a row without a new event shows up once
    property p_reported_once;
        (rd_flags_done && prdata_reg[pisb_pkg::BIT_SYM_ERR] && !evt_bus.evt[pisb_pkg::BIT_SYM_ERR])
            |=> !flags_reg[pisb_pkg::BIT_SYM_ERR];
    endproperty
    a_reported_once: assert property (p_reported_once) else $error("flag survived its read");

    // Summary always has a cause below it
    property p_summary_cause;
        flags_reg[pisb_pkg::BIT_SUMMARY] |-> (|flags_reg[14:0]);
    endproperty
    a_summary_cause: assert property (p_summary_cause) else $error("summary set with no cause");

    // Any cause raises the summary on the same edge
    property p_summary_follows;
        evt_any |=> flags_reg[pisb_pkg::BIT_SUMMARY];
    endproperty
    a_summary_follows: assert property (p_summary_follows) else $error("summary not raised");

    // Auto-negotiation gated flags stay low while it is disabled
    property p_an_gate;
        (!cfg_reg[pisb_pkg::CFG_AN_EN] && !flags_reg[pisb_pkg::BIT_SPEED_CHG]
            && !flags_reg[pisb_pkg::BIT_DPLX_CHG])
            |=> !flags_reg[pisb_pkg::BIT_SPEED_CHG] && !flags_reg[pisb_pkg::BIT_DPLX_CHG];
    endproperty
    a_an_gate: assert property (p_an_gate) else $error("gated flag raised without auto-negotiation");

    // Downshift needs every advertised speed
    property p_adv_gate;
        (!(&cfg_reg[pisb_pkg::CFG_ADV_LSB +: pisb_pkg::CFG_ADV_W]) && !flags_reg[pisb_pkg::BIT_DOWNSHIFT])
            |=> !flags_reg[pisb_pkg::BIT_DOWNSHIFT];
    endproperty
    a_adv_gate: assert property (p_adv_gate) else $error("downshift flag raised without advertisement");

    // Carrier extension suppresses the receive error flag
    property p_rx_ext;
        (RX_CARRIER_EXT && !flags_reg[pisb_pkg::BIT_RX_ERR]) |=> !flags_reg[pisb_pkg::BIT_RX_ERR];
    endproperty
    a_rx_ext: assert property (p_rx_ext) else $error("receive error flag during carrier extension");

    // Writes to the flag word change nothing
    property p_flags_ro;
        (wr_done && addr_is(PADDR, pisb_pkg::ADDR_FLAGS) && (evt_bus.evt == 16'h0000))
            |=> (flags_reg == $past(flags_reg));
    endproperty
    a_flags_ro: assert property (p_flags_ro) else $error("write altered the flags");

    // Downshift with full advertisement is caught
    property p_downshift;
        (SPEED_DOWNSHIFT && (&cfg_reg[pisb_pkg::CFG_ADV_LSB +: pisb_pkg::CFG_ADV_W]))
            |=> flags_reg[pisb_pkg::BIT_DOWNSHIFT];
    endproperty
    a_downshift: assert property (p_downshift) else $error("downshift not flagged");

    // Resolution error is caught
    property p_ms_err;
        MS_RESOLVE_ERROR |=> flags_reg[pisb_pkg::BIT_MS_ERR];
    endproperty
    a_ms_err: assert property (p_ms_err) else $error("resolution error not flagged");

    // Duplex change with auto-negotiation on is caught within two edges
    property p_dplx_change;
        ($changed(FULL_DUPLEX) && cfg_reg[pisb_pkg::CFG_AN_EN] && $past(rst_n_reg, 2))
            |-> ##[0:1] flags_reg[pisb_pkg::BIT_DPLX_CHG];
    endproperty
    a_dplx_change: assert property (p_dplx_change) else $error("duplex change not flagged");

    // Fast link failure and false carrier are caught
    property p_line_events;
        (FAST_LINK_FAIL || FALSE_CARRIER)
            |=> ((flags_reg[pisb_pkg::BIT_FAST_FAIL] || !$past(FAST_LINK_FAIL))
                 && (flags_reg[pisb_pkg::BIT_FALSE_CAR] || !$past(FALSE_CARRIER)));
    endproperty
    a_line_events: assert property (p_line_events) else $error("line event not flagged");

    property p_false_carrier;
        FALSE_CARRIER |=> flags_reg[pisb_pkg::BIT_FALSE_CAR];
    endproperty
    a_false_carrier: assert property (p_false_carrier) else $error("false carrier not flagged");

    // Reserved positions never set
    property p_reserved;
        (flags_reg & ~pisb_pkg::FLAG_IMPL) == 16'h0000;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved flag bit set");

    // Unmapped address answers with an error in the access cycle
    property p_unmapped;
        (setup_phase && !addr_mapped(PADDR)) |=> (PREADY && PSLVERR);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access without error");

    // Mapped address answers cleanly in the access cycle
    property p_mapped;
        (setup_phase && addr_mapped(PADDR)) |=> (PREADY && !PSLVERR);
    endproperty
    a_mapped: assert property (p_mapped) else $error("mapped access answered wrongly");

    // Ready lasts a single cycle
    property p_ready_pulse;
        PREADY |=> !PREADY;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");

    // Interrupt rises one edge after an unmasked flag
    property p_irq_rise;
        (|(flags_reg & mask_reg)) |=> IRQ;
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("interrupt missing for unmasked flag");
endmodule

// ---- pisb_top_tb.sv ----
/* Testbench for the interrupt status bank: APB tasks, event pulses, level changes.
   Assumes pisb_pkg and the design files are compiled first. */
`timescale 1ns/1ps
module pisb_top_tb;
    // ****************
    // Signals and dut
    // ****************
    logic        clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, rce = 0;
    logic [7:0]  paddr = 8'h00, ev = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic [3:0]  lv = 4'h0;
    logic        pready, pslverr, irq, serr;
    int          err_total = 0, checks_done = 0, cyc = 0;
    int          fbit [8] = '{11, 10, 8, 7, 3, 2, 1, 0};

    pisb_top dut (.SYS_CLK(clk), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .LINK_SPEED(lv[2:1]), .LINK_UP(lv[3]), .FULL_DUPLEX(lv[0]), .AN_ERROR(ev[0]),
        .AN_COMPLETE(ev[1]), .SYMBOL_ERROR(ev[2]), .FAST_LINK_FAIL(ev[3]), .FALSE_CARRIER(ev[4]),
        .SPEED_DOWNSHIFT(ev[5]), .MS_RESOLVE_ERROR(ev[6]), .RX_ERROR(ev[7]),
        .RX_CARRIER_EXT(rce), .IRQ(irq));

    // 200 MHz clock and hang ceiling
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            tally_and_finish();
        end
    end

    // ****************
    // Tasks
    // ****************
    task automatic tally_and_finish();
        if (err_total == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One APB transfer; request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rdat = prdata;
        serr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, rdat, exp);
    endtask

    // One-cycle event pulse on the chosen inputs
    task automatic pulse(input logic [7:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 8'h00;
        repeat (3) @(posedge clk);
    endtask

    // New link levels, then read and clear flags
    task automatic setlv(input logic [3:0] v, input logic [31:0] exp);
        @(posedge clk);
        lv <= v;
        repeat (3) @(posedge clk);
        rd("level flags", 8'h68, exp);
    endtask

    // ****************
    // Sequence
    // ****************
    initial begin
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rd("flags reset", 8'h68, 32'h0);
        rd("cfg reset", 8'h60, 32'h1F);
        rd("mask reset", 8'h64, 32'h0);
        apb(1'b1, 8'h68, 32'hFFFF);
        rd("flags ro", 8'h68, 32'h0);
        rd("unmapped", 8'h00, 32'h0);
        chk("slverr", {31'h0, serr}, 32'h1);
        // Each event alone, summary rides along, read clears
        for (int i = 0; i < 8; i++) begin
            pulse(8'h01 << i);
            rd("event", 8'h68, 32'h8000 | (32'h1 << fbit[i]));
            rd("cleared", 8'h68, 32'h0);
        end
        setlv(4'b1000, 32'hA000);
        setlv(4'b1100, 32'hC000);
        setlv(4'b1101, 32'h9000);
        // Missing advertisement bit drops downshift only
        apb(1'b1, 8'h60, 32'h0F);
        pulse(8'h20);
        setlv(4'b1011, 32'hC000);
        // Auto-negotiation off drops speed and duplex changes
        apb(1'b1, 8'h60, 32'h1E);
        pulse(8'h20);
        setlv(4'b1000, 32'h8004);
        // Carrier extension hides receive errors
        rce <= 1'b1;
        pulse(8'h80);
        rd("rx ext", 8'h68, 32'h0);
        rce <= 1'b0;
        apb(1'b1, 8'h60, 32'h1F);
        pulse(8'hFF);
        rd("all events", 8'h68, 32'h8D8F);
        // Mask and interrupt
        apb(1'b1, 8'h64, 32'hFFFF);
        rd("mask rw", 8'h64, 32'hFD8F);
        apb(1'b1, 8'h64, 32'h0008);
        pulse(8'h04);
        @(negedge clk);
        chk("irq masked", {31'h0, irq}, 32'h0);
        pulse(8'h10);
        @(negedge clk);
        chk("irq", {31'h0, irq}, 32'h1);
        rd("flags pair", 8'h68, 32'h8108);
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        tally_and_finish();
    end
endmodule
